// File: logic/pdm_pkg.sv
// Constants for the power-down mode controller.
// Assumes a single 20 MHz system clock domain.
package pdm_pkg;
  // Power-down select field position inside the cpu control/status word.
  localparam int PDM_FIELD_LSB = 10;
  localparam int PDM_FIELD_MSB = 15;
  localparam logic [5:0] PDM_SEL_NONE = 6'h00;
  localparam logic [5:0] PDM_SEL_SLEEP_EN = 6'h09;
  localparam logic [5:0] PDM_SEL_SLEEP_ANY = 6'h11;
  localparam logic [5:0] PDM_SEL_PLL_OUT = 6'h1a;
  localparam logic [5:0] PDM_SEL_PLL_IN = 6'h1c;
  localparam logic [5:0] PDM_FIELD_RST = 6'h00;
  // Sleep takes effect this many cycles after the write is taken (exactly eight).
  localparam logic [3:0] PDM_SLEEP_DELAY = 4'h8;
  // PLL lock time in microseconds and the matching cycle count at 20 MHz.
  localparam int PDM_CLK_MHZ = 20;
  localparam int PDM_LOCK_US = 75;
  localparam int PDM_LOCK_CYCLES = PDM_LOCK_US * PDM_CLK_MHZ;
  localparam logic [11:0] PDM_LOCK_CNT = 12'(PDM_LOCK_CYCLES);

  typedef enum logic [2:0] {
    PDM_ST_RUN = 3'b000,
    PDM_ST_PEND = 3'b001,
    PDM_ST_SLEEP = 3'b010,
    PDM_ST_ISR = 3'b011,
    PDM_ST_PLL_OUT = 3'b100,
    PDM_ST_PLL_IN = 3'b101,
    PDM_ST_RELOCK = 3'b110
  } pdm_state_t;
endpackage

// File: logic/pdm_sync.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the level is slow compared with clk.
`timescale 1ns/1ns
module pdm_sync (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic din, // Asynchronous level.
  output logic dout // Synchronised level.
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule

// File: logic/pdm_ctrl.sv
// Power-down mode controller: decodes the power-down select field and drives
// clock gates for the cpu core, the pll output and the pll input.
// Assumes field writes and interrupt flags come from logic on clk; the
// emulator-attached level arrives from a pin and is synchronised here.
//
// Function
// - Bits 15..10 select mode; zero means none.
// - Sleep begins eight cycles after write.
// - Non-enabled wake resumes without service routine.
// - Enabled wake runs service routine, then resumes.
// - Code 001001 sleeps until enabled interrupt.
// - Code 010001 sleeps until any interrupt.
// - Sleep gates cpu clock; interrupt logic runs.
// - Dma transfers keep running during sleep.
// - Code 011010 halts pll output clock.
// - Code 011100 stops pll input clock.
// - Chip halts leave only by device reset.
// - Chip halts preserve registers and ram.
// - Outputs freeze in chip halt modes.
// - Wake from input halt waits relock.
// - Only main input clock is gated.
// - Attached emulator masks programmed modes.
// - Masking lasts until emulator reset/unplug.
// - Halted chip spins emulation commands idle.
`timescale 1ns/1ns
module pdm_ctrl (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic sys_rst, // Device reset, asynchronous, active high.
  input wire logic csr_wr, // Pulse: cpu writes the control/status word.
  input wire logic [15:0] csr_wdata, // Low half of the written control/status word.
  input wire logic irq_pending, // Level: some interrupt flag is set.
  input wire logic irq_enabled, // Level: a pending interrupt is also enabled.
  input wire logic emu_attached, // Pin level: emulator cable present and not in reset.
  input wire logic emu_cmd, // Pulse: emulator issues a step or run command.
  input wire logic dma_req, // Level: dma engine wants a transfer.
  output logic [5:0] power_down_select_field, // Current field value.
  output logic cpu_clk_en, // Cpu boundary clock gate, high passes clock.
  output logic pll_out_en, // Pll output clock gate, high passes clock.
  output logic main_input_clock_en, // Main input clock gate into the pll.
  output logic dma_clk_en, // Clock gate for the dma transfer engine.
  output logic irq_clk_en, // Clock gate for the interrupt logic.
  output logic isr_take, // Pulse: cpu must run the service routine on wake.
  output logic resume, // Pulse: cpu resumes at the sleep instruction.
  output logic io_freeze, // Functional outputs hold their last state.
  output logic emu_spin, // Emulation commands spin in idle.
  output logic pc_write_fail, // Program counter writes are refused.
  output logic pll_locked // Normal clocking permitted.
);
  import pdm_pkg::*;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  // Returns true when a code is one of the documented modes.
  function automatic logic pdm_valid(input logic [5:0] code);
    pdm_valid = (code == PDM_SEL_SLEEP_EN) || (code == PDM_SEL_SLEEP_ANY) ||
                (code == PDM_SEL_PLL_OUT) || (code == PDM_SEL_PLL_IN);
  endfunction

  // The emulator command pulse and the dma request change no mode: commands
  // only spin while halted and the dma clock runs on through sleep, so both
  // inputs are deliberately left unread.
  logic emu_sync;

  pdm_sync u_emu_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(emu_attached),
    .dout(emu_sync)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pdm_state_t state_reg;
  pdm_state_t state_next;
  logic [5:0] field_reg;
  logic [5:0] field_next;
  logic [3:0] delay_reg;
  logic [3:0] delay_next;
  logic [11:0] lock_reg;
  logic [11:0] lock_next;
  logic cpu_en_reg;
  logic cpu_en_next;
  logic pll_out_reg;
  logic pll_out_next;
  logic in_en_reg;
  logic in_en_next;
  logic dma_en_reg;
  logic dma_en_next;
  logic isr_reg;
  logic isr_next;
  logic resume_reg;
  logic resume_next;
  logic freeze_reg;
  logic freeze_next;
  logic spin_reg;
  logic spin_next;
  logic locked_reg;
  logic locked_next;
  logic [5:0] wr_code;
  logic wake_ok;
  logic lock_done;

  assign wr_code = csr_wdata[PDM_FIELD_MSB:PDM_FIELD_LSB];
  // Any-interrupt mode wakes on a pending flag, the other needs it enabled.
  assign wake_ok = (field_reg == PDM_SEL_SLEEP_ANY) ? irq_pending : irq_enabled;
  assign lock_done = (lock_reg == 12'h000);

  always_comb begin
    state_next = state_reg;
    field_next = field_reg;
    delay_next = delay_reg;
    lock_next = lock_reg;
    isr_next = 1'b0;
    resume_next = 1'b0;
    case (state_reg)
      PDM_ST_RELOCK: begin
        // Clocks stay off the cpu until the pll has had its lock time.
        if (lock_done) begin
          state_next = PDM_ST_RUN;
        end else begin
          lock_next = lock_reg - 12'h001;
        end
      end
      PDM_ST_RUN: begin
        // Writes in any other state are dropped, even in PDM_ST_PEND and PDM_ST_ISR where the cpu clock still runs.
        if (csr_wr) begin
          field_next = wr_code;
          // A reserved code, bit 15 set included, is stored but does nothing.
          if (pdm_valid(wr_code) && !emu_sync) begin
            state_next = PDM_ST_PEND;
            delay_next = PDM_SLEEP_DELAY - 4'h1;
          end
        end
      end
      PDM_ST_PEND: begin
        // The count starts at the write edge, so the gate drops eight edges later.
        if (emu_sync) begin
          state_next = PDM_ST_RUN;
        end else if (delay_reg != 4'h0) begin
          delay_next = delay_reg - 4'h1;
        end else if (field_reg == PDM_SEL_PLL_OUT) begin
          state_next = PDM_ST_PLL_OUT;
        end else if (field_reg == PDM_SEL_PLL_IN) begin
          state_next = PDM_ST_PLL_IN;
        end else begin
          state_next = PDM_ST_SLEEP;
        end
      end
      PDM_ST_SLEEP: begin
        // An emulator attached mid-sleep wakes the cpu quietly, with no resume pulse.
        if (emu_sync) begin
          state_next = PDM_ST_RUN;
          field_next = PDM_SEL_NONE;
        end else if (wake_ok) begin
          field_next = PDM_SEL_NONE;
          if (irq_enabled) begin
            isr_next = 1'b1;
            state_next = PDM_ST_ISR;
          end else begin
            resume_next = 1'b1;
            state_next = PDM_ST_RUN;
          end
        end
      end
      PDM_ST_ISR: begin
        // The cpu runs the handler, then returns to the sleep instruction.
        resume_next = 1'b1;
        state_next = PDM_ST_RUN;
      end
      PDM_ST_PLL_OUT, PDM_ST_PLL_IN: begin
        // Interrupts and writes are ignored; only reset leaves.
        state_next = state_reg;
      end
      default: begin
        // The one unused state code falls back to normal running.
        state_next = PDM_ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Gate and status outputs
  // ----------------------------------------------------------------------
  always_comb begin
    cpu_en_next = 1'b1;
    pll_out_next = 1'b1;
    in_en_next = 1'b1;
    dma_en_next = 1'b1;
    freeze_next = 1'b0;
    spin_next = 1'b0;
    locked_next = 1'b1;
    case (state_next)
      PDM_ST_SLEEP: begin
        // Dma and interrupt clocks stay on so transfers and wake-up still work.
        cpu_en_next = 1'b0;
        dma_en_next = 1'b1;
      end
      PDM_ST_PLL_OUT: begin
        // Register and ram contents hold because nothing is reset here.
        cpu_en_next = 1'b0;
        pll_out_next = 1'b0;
        dma_en_next = 1'b0;
        freeze_next = 1'b1;
        spin_next = 1'b1;
      end
      PDM_ST_PLL_IN: begin
        cpu_en_next = 1'b0;
        pll_out_next = 1'b0;
        // Only the main input clock is stopped; other input clocks pass untouched.
        in_en_next = 1'b0;
        dma_en_next = 1'b0;
        freeze_next = 1'b1;
        spin_next = 1'b1;
      end
      PDM_ST_RELOCK: begin
        cpu_en_next = 1'b0;
        pll_out_next = 1'b0;
        dma_en_next = 1'b0;
        locked_next = 1'b0;
      end
      default: begin
        cpu_en_next = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Every reset reloads the lock count, not only one out of input halt: the
  // halt state is lost in reset, so relocking each time is the safe choice.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= PDM_ST_RELOCK;
      field_reg <= PDM_FIELD_RST;
      delay_reg <= 4'h0;
      lock_reg <= PDM_LOCK_CNT;
    end else begin
      state_reg <= state_next;
      field_reg <= field_next;
      delay_reg <= delay_next;
      lock_reg <= lock_next;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_en_reg <= 1'b0;
      pll_out_reg <= 1'b0;
      in_en_reg <= 1'b1;
      dma_en_reg <= 1'b0;
      isr_reg <= 1'b0;
      resume_reg <= 1'b0;
      freeze_reg <= 1'b0;
      spin_reg <= 1'b0;
      locked_reg <= 1'b0;
    end else begin
      cpu_en_reg <= cpu_en_next;
      pll_out_reg <= pll_out_next;
      in_en_reg <= in_en_next;
      dma_en_reg <= dma_en_next;
      isr_reg <= isr_next;
      resume_reg <= resume_next;
      freeze_reg <= freeze_next;
      spin_reg <= spin_next;
      locked_reg <= locked_next;
    end
  end

  logic irq_en_reg;

  // Interrupt logic clock never gated; held as a flop for a clean output.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_reg <= 1'b1;
    end else begin
      irq_en_reg <= 1'b1;
    end
  end

  assign power_down_select_field = field_reg;
  assign cpu_clk_en = cpu_en_reg;
  assign pll_out_en = pll_out_reg;
  assign main_input_clock_en = in_en_reg;
  assign dma_clk_en = dma_en_reg;
  assign irq_clk_en = irq_en_reg;
  assign isr_take = isr_reg;
  assign resume = resume_reg;
  assign io_freeze = freeze_reg;
  assign emu_spin = spin_reg;
  assign pc_write_fail = spin_reg;
  assign pll_locked = locked_reg;
endmodule

// File: verif/pdm_ctrl_monitor.sv
// Checker for the power-down controller, bound to every pdm_ctrl.
// Assumes interrupt lines stay quiet while a mode is still pending.
`timescale 1ns/1ns
module pdm_ctrl_monitor
  import pdm_pkg::*;
(
  input wire logic clk, // In.
  input wire logic sys_rst, // In.
  input wire logic csr_wr, // In.
  input wire logic [15:0] csr_wdata, // In.
  input wire logic irq_pending, // In.
  input wire logic irq_enabled, // In.
  input wire logic emu_attached, // In.
  input wire logic [5:0] power_down_select_field, // In.
  input wire logic cpu_clk_en, // In.
  input wire logic pll_out_en, // In.
  input wire logic main_input_clock_en, // In.
  input wire logic isr_take, // In.
  input wire logic resume, // In.
  input wire logic io_freeze, // In.
  input wire logic pc_write_fail, // In.
  input wire logic pll_locked // In.
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr_ok, idle_code, asleep;
  logic [5:0] wr_code;
  assign wr_code = csr_wdata[PDM_FIELD_MSB:PDM_FIELD_LSB];
  assign wr_ok = csr_wr && cpu_clk_en && pll_out_en && pll_locked && !emu_attached;
  assign idle_code = !(wr_code inside {PDM_SEL_SLEEP_EN, PDM_SEL_SLEEP_ANY, PDM_SEL_PLL_OUT,
    PDM_SEL_PLL_IN});
  assign asleep = !cpu_clk_en && pll_out_en && main_input_clock_en && pll_locked;
  sleep_delay_a: assert property (wr_ok && wr_code == PDM_SEL_SLEEP_EN
    |=> cpu_clk_en [*8] ##1 !cpu_clk_en) else $error("sleep gate timing wrong");
  halt_delay_a: assert property (wr_ok && wr_code == PDM_SEL_PLL_OUT
    |=> pll_out_en [*8] ##1 !pll_out_en) else $error("halt gate timing wrong");
  idle_hold_a: assert property (wr_ok && idle_code
    |=> (cpu_clk_en && pll_out_en && main_input_clock_en) [*8]) else $error("idle code gated");
  en_hold_a: assert property (asleep && !irq_enabled && !emu_attached
    && power_down_select_field == PDM_SEL_SLEEP_EN |=> !cpu_clk_en) else $error("early wake");
  any_wake_a: assert property (asleep && irq_pending && !irq_enabled
    && power_down_select_field == PDM_SEL_SLEEP_ANY |=> cpu_clk_en && resume && !isr_take)
    else $error("plain wake wrong");
  isr_wake_a: assert property (asleep && irq_enabled
    |=> isr_take && cpu_clk_en ##1 resume) else $error("service wake wrong");
  halt_hold_a: assert property (io_freeze
    |=> io_freeze && pc_write_fail && $stable(power_down_select_field)) else $error("halt left");
  relock_wait_a: assert property ($fell(sys_rst)
    |-> !pll_locked [*8]) else $error("lock too early");
  emu_mask_a: assert property (emu_attached && $past(emu_attached, 4)
    && pll_locked && !io_freeze |-> cpu_clk_en) else $error("mode not masked");
endmodule
bind pdm_ctrl pdm_ctrl_monitor pdm_ctrl_monitor_inst (.clk, .sys_rst, .csr_wr, .csr_wdata,
  .irq_pending, .irq_enabled, .emu_attached, .power_down_select_field, .cpu_clk_en,
  .pll_out_en, .main_input_clock_en, .isr_take, .resume, .io_freeze, .pc_write_fail, .pll_locked);

// File: verif/pdm_cpu_model.sv
// Cpu core, interrupt logic and emulator seen from the controller.
// Assumes callers wait for each task to return before the next request.
`timescale 1ns/1ns
module pdm_cpu_model (
  input wire logic clk, // System clock.
  output logic csr_wr, // Write pulse.
  output logic [15:0] csr_wdata, // Written word.
  output logic irq_pending, // Any flag set.
  output logic irq_enabled, // Enabled flag set.
  output logic emu_attached, // Cable level.
  output logic emu_cmd, // Step or run pulse.
  output logic dma_req // Dma activity.
);
  initial {csr_wr, csr_wdata, irq_pending, irq_enabled, emu_attached, emu_cmd, dma_req} = '0;
  // The whole field goes in one write; the top bit is set only for refusal cases.
  task automatic write_field(input logic [5:0] code);
    @(posedge clk);
    csr_wr <= 1'b1;
    csr_wdata <= {code, 10'h155};
    @(posedge clk);
    csr_wr <= 1'b0;
    csr_wdata <= ~csr_wdata;
  endtask
  task automatic set_lines(input logic pend, input logic en, input logic emu, input logic cmd);
    @(posedge clk);
    irq_pending <= pend;
    irq_enabled <= en;
    emu_attached <= emu;
    emu_cmd <= cmd;
    dma_req <= ~dma_req;
  endtask
endmodule

// File: verif/tb_power_down_mode_logic.sv
// Self-checking bench for pdm_ctrl with the cpu model on its far side.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ns
module tb_power_down_mode_logic;
  import pdm_pkg::*;
  logic clk, sys_rst, csr_wr, irq_pending, irq_enabled, emu_attached, emu_cmd, dma_req;
  logic [15:0] csr_wdata;
  logic [5:0] power_down_select_field;
  logic cpu_clk_en, pll_out_en, main_input_clock_en, dma_clk_en, irq_clk_en, isr_take, resume;
  logic io_freeze, emu_spin, pc_write_fail, pll_locked;
  int bad_count, cmp_count, isr_seen, res_seen;
  pdm_ctrl pdm_ctrl_inst (.clk, .sys_rst, .csr_wr, .csr_wdata, .irq_pending, .irq_enabled,
    .emu_attached, .emu_cmd, .dma_req, .power_down_select_field, .cpu_clk_en, .pll_out_en,
    .main_input_clock_en, .dma_clk_en, .irq_clk_en, .isr_take, .resume, .io_freeze, .emu_spin,
    .pc_write_fail, .pll_locked);
  pdm_cpu_model pdm_cpu_model_inst (.clk, .csr_wr, .csr_wdata, .irq_pending, .irq_enabled,
    .emu_attached, .emu_cmd, .dma_req);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (isr_take === 1'b1) isr_seen++;
    if (resume === 1'b1) res_seen++;
  end
  // -------
  // Helpers
  // -------
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic gate(input int w);
    return w == 0 ? cpu_clk_en : (w == 1 ? pll_out_en : main_input_clock_en);
  endfunction
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic fall_count(input int w, output int n);
    #1;
    n = 0;
    while (gate(w) === 1'b1 && n < 30) begin
      edges(1);
      n++;
    end
  endtask
  task automatic do_reset();
    int n;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    edges(3);
    check("locked_early", pll_locked, 16'h0);
    n = 0;
    while (pll_locked !== 1'b1 && n < 2000) begin
      edges(1);
      n++;
    end
    check("relock_len", 16'(n > PDM_LOCK_CYCLES - 10 && n <= PDM_LOCK_CYCLES), 16'h1);
    check("run_gates", {cpu_clk_en, pll_out_en, main_input_clock_en}, 16'h7);
    check("field_rst", power_down_select_field, 16'(PDM_FIELD_RST));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_sleep(input logic [5:0] code);
    int n;
    isr_seen = 0;
    res_seen = 0;
    pdm_cpu_model_inst.write_field(code);
    fall_count(0, n);
    check("sleep_delay", 16'(n), 16'(PDM_SLEEP_DELAY));
    check("sleep_field", power_down_select_field, 16'(code));
    check("side_gates", {dma_clk_en, irq_clk_en}, 16'h3);
    pdm_cpu_model_inst.set_lines(1'b1, 1'b0, 1'b0, 1'b0);
    edges(5);
    check("plain_irq", cpu_clk_en, 16'(code == PDM_SEL_SLEEP_ANY));
    pdm_cpu_model_inst.set_lines(1'b1, 1'b1, 1'b0, 1'b0);
    edges(5);
    check("isr_runs", 16'(isr_seen), 16'(code == PDM_SEL_SLEEP_EN));
    check("resumed", 16'(res_seen), 16'h1);
    check("wake_field", {cpu_clk_en, 3'h0, power_down_select_field}, 16'h200);
    pdm_cpu_model_inst.set_lines(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_reserved();
    logic [5:0] codes [4] = '{6'h01, 6'h19, 6'h1b, 6'h29};
    foreach (codes[i]) begin
      pdm_cpu_model_inst.write_field(codes[i]);
      edges(12);
      check("rsv_gates", {cpu_clk_en, pll_out_en, main_input_clock_en}, 16'h7);
      check("rsv_field", power_down_select_field, 16'(codes[i]));
    end
  endtask
  task automatic t_emu();
    pdm_cpu_model_inst.set_lines(1'b0, 1'b0, 1'b1, 1'b0);
    edges(4);
    pdm_cpu_model_inst.write_field(PDM_SEL_SLEEP_ANY);
    edges(12);
    check("emu_mask", cpu_clk_en, 16'h1);
    pdm_cpu_model_inst.set_lines(1'b0, 1'b0, 1'b0, 1'b0);
    edges(4);
    t_sleep(PDM_SEL_SLEEP_ANY);
  endtask
  task automatic t_halt(input logic [5:0] code, input int w);
    int n;
    pdm_cpu_model_inst.write_field(code);
    fall_count(w, n);
    check("halt_delay", 16'(n), 16'(PDM_SLEEP_DELAY));
    pdm_cpu_model_inst.set_lines(1'b1, 1'b1, 1'b0, 1'b1);
    pdm_cpu_model_inst.set_lines(1'b1, 1'b1, 1'b0, 1'b0);
    edges(20);
    check("halt_gate", gate(w), 16'h0);
    check("halt_freeze", {io_freeze, emu_spin, pc_write_fail}, 16'h7);
    check("halt_field", power_down_select_field, 16'(code));
    pdm_cpu_model_inst.set_lines(1'b0, 1'b0, 1'b0, 1'b0);
    do_reset();
  endtask
  initial begin
    sys_rst = 1'b1;
    do_reset();
    t_sleep(PDM_SEL_SLEEP_EN);
    $display("test sleep_enabled done");
    t_sleep(PDM_SEL_SLEEP_ANY);
    $display("test sleep_any done");
    t_reserved();
    $display("test reserved done");
    t_emu();
    $display("test emulator done");
    t_halt(PDM_SEL_PLL_OUT, 1);
    $display("test pll_out_halt done");
    t_halt(PDM_SEL_PLL_IN, 2);
    $display("test pll_in_halt done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule
